// *** core/p3cm_regs.svh ***
`ifndef P3CM_REGS_SVH
`define P3CM_REGS_SVH
`define P3CM_BANK_F 4'hf
`define P3CM_CFG_ADDR 4'h0
`define P3CM_CFG_RESET 8'h00
`define P3CM_CFG_CMP_OUT 0
`define P3CM_MODE_ANALOG 1
`define P3CM_MODE_LOWEMI 0
`define P3CM_IRQ_EDGE_LO 6
`define P3CM_IRQ_EDGE_HI 7
`define P3CM_KEEP_W 4
`endif

// *** core/p3cm_pkg.sv ***
package p3cm_pkg;
   typedef struct packed {
      logic in1;
      logic in2;
      logic in3;
   } p3cm_pins_t;
   typedef struct packed {
      logic int_0;
      logic int_1;
      logic int_2;
   } p3cm_ints_t;
   typedef enum logic [1:0] {
      P3CM_EDGE_FALL,
      P3CM_EDGE_RISE,
      P3CM_EDGE_BOTH
   } p3cm_edge_t;
endpackage

// *** core/p3cm_sync.sv ***
`timescale 1ns/1ps
module p3cm_sync #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s1_nxt;
   logic [W-1:0] q_nxt;
   always_comb begin
      s1_nxt = clk_en ? d : s1_r;
      q_nxt = clk_en ? s1_r : q;
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s1_r <= '0;
         q <= '0;
      end else begin
         s1_r <= s1_nxt;
         q <= q_nxt;
      end
   end
endmodule // p3cm_sync

// *** core/p3cm_keeper.sv ***
`timescale 1ns/1ps
// holds the last sensed level on undriven inputs
module p3cm_keeper #(
   parameter int W = 4,
   parameter bit ENABLE = 1'b1
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [W-1:0] pin_in,
   input wire logic [W-1:0] pin_driven,
   output logic [W-1:0] keep_out,
   output logic [W-1:0] keep_oe
);
   logic [W-1:0] lvl_r;
   logic [W-1:0] lvl_nxt;
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_comb begin
            lvl_nxt[g] = (clk_en && pin_driven[g]) ? pin_in[g] : lvl_r[g];
         end
         assign keep_out[g] = lvl_r[g];
         assign keep_oe[g] = ENABLE && !pin_driven[g];
      end
   endgenerate
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lvl_r <= '0;
      end else begin
         lvl_r <= lvl_nxt;
      end
   end
endmodule // p3cm_keeper

// *** core/p3cm_port3.sv ***
`timescale 1ns/1ps
`include "p3cm_regs.svh"
module p3cm_port3 import p3cm_pkg::*; #(
   parameter bit KEEPER_EN = 1'b1
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic power_on_reset,
   input wire logic watchdog_reset,
   input wire logic stop_mode,
   input wire p3cm_pins_t pins_in,
   input wire logic comparator_a_raw,
   input wire logic comparator_b_raw,
   input wire logic [7:0] port3_mode_reg,
   input wire logic [7:0] interrupt_request_reg,
   input wire logic [3:0] erf_bank,
   input wire logic [3:0] erf_addr,
   input wire logic erf_wr,
   input wire logic [7:0] erf_wdata,
   input wire logic [2:0] port3_out_reg,
   input wire logic timer1_out,
   input wire logic port0_hs_out,
   input wire logic port2_hs_out,
   input wire logic stop_recovery_src,
   input wire logic [`P3CM_KEEP_W-1:0] other_in,
   input wire logic [`P3CM_KEEP_W-1:0] other_driven,
   output logic [`P3CM_KEEP_W-1:0] keep_out,
   output logic [`P3CM_KEEP_W-1:0] keep_oe,
   output logic port3_output_4,
   output logic port3_output_5,
   output logic port3_output_6,
   output logic low_emi_drive,
   output logic analog_en,
   output logic comp_a_en,
   output logic comp_b_en,
   output logic [2:0] port3_read,
   output logic timer1_in,
   output logic port0_hs_in,
   output logic port2_hs_in,
   output p3cm_ints_t ext_int
);
   // ==========================================
   // input synchronisation
   p3cm_pins_t pins_s;
   logic comp_a_s;
   logic comp_b_s;
   // plain inputs, only synchronised, no keeper
   p3cm_sync #(.W(3)) u_pin_sync (
      .clock(clock),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .d(pins_in),
      .q(pins_s)
   );
   p3cm_sync #(.W(2)) u_cmp_sync (
      .clock(clock),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .d({comparator_a_raw, comparator_b_raw}),
      .q({comp_a_s, comp_b_s})
   );
   // ==========================================
   // auto latch keeper on the other port inputs
   p3cm_keeper #(.W(`P3CM_KEEP_W), .ENABLE(KEEPER_EN)) u_keeper (
      .clock(clock),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .pin_in(other_in),
      .pin_driven(other_driven),
      .keep_out(keep_out),
      .keep_oe(keep_oe)
   );
   // ==========================================
   // port configuration register
   logic [7:0] cfg_r;
   logic [7:0] cfg_nxt;
   logic cfg_clear;
   // a watchdog bite while stopped leaves the comparator routing intact
   assign cfg_clear = power_on_reset || (watchdog_reset && !stop_mode);
   always_comb begin
      cfg_nxt = cfg_r;
      if (cfg_clear) begin
         cfg_nxt = `P3CM_CFG_RESET;
      end else if (clk_en && erf_wr && erf_bank == `P3CM_BANK_F
                   && erf_addr == `P3CM_CFG_ADDR) begin
         cfg_nxt = erf_wdata;
      end
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cfg_r <= `P3CM_CFG_RESET;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end
   // ==========================================
   // mode decode
   assign analog_en = port3_mode_reg[`P3CM_MODE_ANALOG];
   assign low_emi_drive = port3_mode_reg[`P3CM_MODE_LOWEMI];
   assign comp_a_en = analog_en;
   assign comp_b_en = analog_en;
   // ==========================================
   // input 3 register bit and edge sources
   logic in3_bit_r;
   logic in3_bit_nxt;
   logic src_prev_r;
   logic src_prev_nxt;
   logic [2:0] prev_r;
   logic [2:0] prev_nxt;
   logic [2:0] cur;
   logic src_edge;
   always_comb begin
      src_prev_nxt = clk_en ? stop_recovery_src : src_prev_r;
      src_edge = clk_en && stop_recovery_src && !src_prev_r;
      in3_bit_nxt = in3_bit_r;
      if (clk_en) begin
         if (analog_en) begin
            in3_bit_nxt = src_edge ? !in3_bit_r : in3_bit_r;
         end else begin
            in3_bit_nxt = pins_s.in3;
         end
      end
      // comparators replace the raw pins in analog mode
      cur[0] = analog_en ? comp_a_s : pins_s.in1;
      cur[1] = analog_en ? comp_b_s : pins_s.in2;
      cur[2] = pins_s.in3;
      prev_nxt = clk_en ? cur : prev_r;
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         in3_bit_r <= 1'b0;
         src_prev_r <= 1'b0;
         prev_r <= 3'h0;
      end else begin
         in3_bit_r <= in3_bit_nxt;
         src_prev_r <= src_prev_nxt;
         prev_r <= prev_nxt;
      end
   end
   assign port3_read = {in3_bit_r, pins_s.in2, pins_s.in1};
   // ==========================================
   // edge select and interrupt generation
   p3cm_edge_t sel1;
   p3cm_edge_t sel2;
   logic [2:0] rise;
   logic [2:0] fall;
   logic hit1;
   logic hit2;
   logic hit3;
   p3cm_ints_t ext_int_nxt;
   always_comb begin
      rise = cur & ~prev_r;
      fall = ~cur & prev_r;
      unique case ({interrupt_request_reg[`P3CM_IRQ_EDGE_HI],
                    interrupt_request_reg[`P3CM_IRQ_EDGE_LO]})
         2'h0: begin
            sel1 = P3CM_EDGE_FALL;
            sel2 = P3CM_EDGE_FALL;
         end
         2'h1: begin
            sel1 = P3CM_EDGE_FALL;
            sel2 = P3CM_EDGE_RISE;
         end
         2'h2: begin
            sel1 = P3CM_EDGE_RISE;
            sel2 = P3CM_EDGE_FALL;
         end
         2'h3: begin
            sel1 = P3CM_EDGE_BOTH;
            sel2 = P3CM_EDGE_BOTH;
         end
      endcase
      hit1 = (sel1 != P3CM_EDGE_RISE && fall[0]) || (sel1 != P3CM_EDGE_FALL && rise[0]);
      hit2 = (sel2 != P3CM_EDGE_RISE && fall[1]) || (sel2 != P3CM_EDGE_FALL && rise[1]);
      // in analog mode the recovery source stands in for the input_3 edge
      hit3 = analog_en ? src_edge : fall[2];
      ext_int_nxt.int_2 = clk_en && hit1;
      ext_int_nxt.int_0 = clk_en && hit2;
      ext_int_nxt.int_1 = clk_en && hit3;
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ext_int <= '0;
      end else begin
         ext_int <= ext_int_nxt;
      end
   end
   // ==========================================
   // pin function routing
   assign timer1_in = pins_s.in1;
   assign port2_hs_in = pins_s.in1;
   assign port0_hs_in = pins_s.in2;
   logic [2:0] out_nxt;
   logic [2:0] out_r;
   always_comb begin
      // only comparator_a may reach a pin; comparator_b is never routed
      out_nxt[0] = cfg_r[`P3CM_CFG_CMP_OUT] ? comp_a_s : port3_out_reg[0];
      out_nxt[1] = port0_hs_out || port3_out_reg[1];
      out_nxt[2] = timer1_out || port2_hs_out || port3_out_reg[2];
      if (!clk_en) begin
         out_nxt = out_r;
      end
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         out_r <= 3'h0;
      end else begin
         out_r <= out_nxt;
      end
   end
   assign port3_output_4 = out_r[0];
   assign port3_output_5 = out_r[1];
   assign port3_output_6 = out_r[2];
   // ==========================================
   // checks
   a_cfg_clear: assert property (@(posedge clock) disable iff (!arst_n)
      cfg_clear |=> cfg_r == 8'h00) else $error("config not cleared");
   a_cfg_stop_keep: assert property (@(posedge clock) disable iff (!arst_n)
      (watchdog_reset && stop_mode && !power_on_reset && !erf_wr) |=> cfg_r == $past(cfg_r))
      else $error("config lost in stop");
   a_cfg_write: assert property (@(posedge clock) disable iff (!arst_n)
      (clk_en && erf_wr && erf_bank == 4'hf && erf_addr == 4'h0 && !cfg_clear)
      |=> cfg_r == $past(erf_wdata)) else $error("config write lost");
   a_out4_comp: assert property (@(posedge clock) disable iff (!arst_n)
      (clk_en && cfg_r[0]) |=> port3_output_4 == $past(comp_a_s))
      else $error("comparator not on output_4");
   a_int1_fall: assert property (@(posedge clock) disable iff (!arst_n)
      (clk_en && !analog_en && prev_r[2] && !pins_s.in3) |=> ext_int.int_1)
      else $error("ext_int_1 missed");
   a_int1_no_rise: assert property (@(posedge clock) disable iff (!arst_n)
      (!analog_en && !prev_r[2] && pins_s.in3) |=> !ext_int.int_1)
      else $error("ext_int_1 on rise");
   a_int0_edge: assert property (@(posedge clock) disable iff (!arst_n)
      (clk_en && !analog_en && interrupt_request_reg[7:6] == 2'h1
       && !prev_r[1] && pins_s.in2) |=> ext_int.int_0)
      else $error("ext_int_0 rise missed");
   a_int2_edge: assert property (@(posedge clock) disable iff (!arst_n)
      (clk_en && !analog_en && interrupt_request_reg[7:6] == 2'h1
       && !prev_r[0] && pins_s.in1) |=> !ext_int.int_2)
      else $error("ext_int_2 on wrong edge");
   a_sync_lat: assert property (@(posedge clock) disable iff (!arst_n)
      (clk_en && $past(clk_en) && $past(clk_en, 2)) |-> pins_s == $past(pins_in, 2))
      else $error("sync latency");
endmodule // p3cm_port3

// *** dv/p3cm_pin_model.sv ***
`timescale 1ns/1ps
// ============================================
// external port 3 pins and comparator front end
module p3cm_pin_model import p3cm_pkg::*; (
   output p3cm_pins_t pins_in,
   output logic comparator_a_raw,
   output logic comparator_b_raw
);
   int a1 = 0;
   int a2 = 0;
   int vref = 50;
   logic [2:0] lvl = 3'h0;
   // in1 sits in the struct msb, so lvl is {in1, in2, in3}
   assign pins_in = lvl;
   // both comparators share the input_3 reference level
   assign comparator_a_raw = (a1 > vref);
   assign comparator_b_raw = (a2 > vref);
   task automatic set_dig(input logic [2:0] v);
      lvl = v;
   endtask
   task automatic set_ana(input int v1, input int v2);
      a1 = v1;
      a2 = v2;
   endtask
endmodule // p3cm_pin_model

// *** dv/port3_comparator_mux_tb.sv ***
`timescale 1ns/1ps
// ============================================
// self-checking bench for the port 3 mux
module port3_comparator_mux_tb import p3cm_pkg::*;;
   logic clock = 1'b0, arst_n = 1'b0, clk_en = 1'b1, erf_wr = 1'b0, timer1_out = 1'b0;
   logic power_on_reset = 1'b0, watchdog_reset = 1'b0, stop_mode = 1'b0;
   logic port0_hs_out = 1'b0, port2_hs_out = 1'b0, stop_recovery_src = 1'b0;
   logic [7:0] port3_mode_reg = 8'h00, interrupt_request_reg = 8'h00, erf_wdata = 8'h00;
   logic [3:0] erf_bank = 4'h0, erf_addr = 4'h0, other_in = 4'h0, other_driven = 4'hf;
   logic [2:0] port3_out_reg = 3'h0, port3_read, p;
   logic [3:0] keep_out, keep_oe;
   logic [1:0] s;
   logic comparator_a_raw, comparator_b_raw, port3_output_4, port3_output_5, port3_output_6;
   logic low_emi_drive, analog_en, comp_a_en, comp_b_en, timer1_in, port0_hs_in, port2_hs_in;
   p3cm_pins_t pins_in;
   p3cm_ints_t ext_int;
   int num_errors = 0, n_compared = 0, seed = 60, c0 = 0, c1 = 0, c2 = 0;

   p3cm_port3 dut_u (
      .clock(clock),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .power_on_reset(power_on_reset),
      .watchdog_reset(watchdog_reset),
      .stop_mode(stop_mode),
      .pins_in(pins_in),
      .comparator_a_raw(comparator_a_raw),
      .comparator_b_raw(comparator_b_raw),
      .port3_mode_reg(port3_mode_reg),
      .interrupt_request_reg(interrupt_request_reg),
      .erf_bank(erf_bank),
      .erf_addr(erf_addr),
      .erf_wr(erf_wr),
      .erf_wdata(erf_wdata),
      .port3_out_reg(port3_out_reg),
      .timer1_out(timer1_out),
      .port0_hs_out(port0_hs_out),
      .port2_hs_out(port2_hs_out),
      .stop_recovery_src(stop_recovery_src),
      .other_in(other_in),
      .other_driven(other_driven),
      .keep_out(keep_out),
      .keep_oe(keep_oe),
      .port3_output_4(port3_output_4),
      .port3_output_5(port3_output_5),
      .port3_output_6(port3_output_6),
      .low_emi_drive(low_emi_drive),
      .analog_en(analog_en),
      .comp_a_en(comp_a_en),
      .comp_b_en(comp_b_en),
      .port3_read(port3_read),
      .timer1_in(timer1_in),
      .port0_hs_in(port0_hs_in),
      .port2_hs_in(port2_hs_in),
      .ext_int(ext_int)
   );
   p3cm_pin_model pm_u (
      .pins_in(pins_in),
      .comparator_a_raw(comparator_a_raw),
      .comparator_b_raw(comparator_b_raw)
   );

   always #12.5 clock = ~clock;
   // interrupt pulses are counted so checks need no exact cycle
   always @(posedge clock) begin
      if (ext_int.int_0 === 1'b1) c0++;
      if (ext_int.int_1 === 1'b1) c1++;
      if (ext_int.int_2 === 1'b1) c2++;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic clr();
      c0 = 0;
      c1 = 0;
      c2 = 0;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] b, input logic [3:0] a, input logic [7:0] d);
      erf_bank = b;
      erf_addr = a;
      erf_wdata = d;
      erf_wr = 1'b1;
      cyc(1);
      erf_wr = 1'b0;
   endtask
   function automatic logic fires(input logic [1:0] sel, input logic b, input logic rise);
      return (sel == 2'b11) || (b == rise);
   endfunction
   task automatic print_verdict();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      #75000;
      num_errors++;
      print_verdict();
   end

   initial begin
      cyc(6);
      arst_n = 1'b1;
      cyc(2);
      chk("out4", port3_output_4, 8'h00);
      chk("ints", ext_int, 8'h00);
      repeat (8) begin
         p = 3'($random(seed));
         port3_out_reg = 3'($random(seed));
         {timer1_out, port0_hs_out, port2_hs_out} = 3'($random(seed));
         port3_mode_reg = {7'h00, 1'($random(seed))};
         other_driven = 4'($random(seed));
         other_in = 4'($random(seed));
         pm_u.set_dig(p);
         cyc(4);
         chk("read", port3_read, {p[0], p[1], p[2]});
         chk("tin", timer1_in, p[2]);
         chk("hsin", {port0_hs_in, port2_hs_in}, {p[1], p[2]});
         chk("out4", port3_output_4, port3_out_reg[0]);
         chk("out5", port3_output_5, port3_out_reg[1] | port0_hs_out);
         chk("out6", port3_output_6, port3_out_reg[2] | timer1_out | port2_hs_out);
         chk("emi", low_emi_drive, port3_mode_reg[0]);
         chk("ana", {analog_en, comp_a_en, comp_b_en}, 8'h00);
         chk("keep", keep_oe, 4'(~other_driven));
         chk("keepv", keep_out & other_driven, other_in & other_driven);
      end
      {timer1_out, port0_hs_out, port2_hs_out, port3_out_reg} = 6'h00;
      for (int k = 0; k < 4; k++) begin
         s = k[1:0];
         interrupt_request_reg = {s, 6'h00};
         for (int r = 0; r < 2; r++) begin
            pm_u.set_dig({~r[0], ~r[0], 1'b1});
            cyc(5);
            clr();
            pm_u.set_dig({r[0], ~r[0], 1'b1});
            cyc(5);
            chk("int2", c2, fires(s, s[1], r[0]));
            pm_u.set_dig({r[0], r[0], 1'b1});
            cyc(5);
            chk("int0", c0, fires(s, s[0], r[0]));
            chk("int1", c1, 8'h00);
         end
      end
      pm_u.set_dig(3'h7);
      cyc(5);
      clr();
      pm_u.set_dig(3'h6);
      cyc(5);
      chk("int1f", c1, 8'h01);
      pm_u.set_dig(3'h7);
      cyc(5);
      chk("int1r", c1, 8'h01);
      // config is write-only, so its effect is seen only on output_4
      pm_u.set_ana(99, 0);
      clk_en = 1'b0;
      wr(4'hf, 4'h0, 8'h01);
      clk_en = 1'b1;
      wr(4'he, 4'h0, 8'h01);
      wr(4'hf, 4'h1, 8'h01);
      cyc(4);
      chk("cfgoff", port3_output_4, 8'h00);
      wr(4'hf, 4'h0, 8'h01);
      cyc(4);
      chk("cmpa", port3_output_4, 8'h01);
      pm_u.set_ana(0, 99);
      cyc(4);
      chk("cmpb", port3_output_4, 8'h00);
      pm_u.set_ana(99, 0);
      stop_mode = 1'b1;
      watchdog_reset = 1'b1;
      cyc(1);
      watchdog_reset = 1'b0;
      stop_mode = 1'b0;
      cyc(4);
      chk("wdstop", port3_output_4, 8'h01);
      watchdog_reset = 1'b1;
      cyc(1);
      watchdog_reset = 1'b0;
      cyc(4);
      chk("wd", port3_output_4, 8'h00);
      wr(4'hf, 4'h0, 8'h01);
      power_on_reset = 1'b1;
      cyc(1);
      power_on_reset = 1'b0;
      cyc(4);
      chk("por", port3_output_4, 8'h00);
      port3_mode_reg = 8'h02;
      interrupt_request_reg = 8'h80;
      pm_u.set_ana(0, 0);
      cyc(5);
      clr();
      chk("anaon", {analog_en, comp_a_en, comp_b_en}, 8'h07);
      pm_u.set_ana(99, 0);
      cyc(5);
      chk("cmpint", c2, 8'h01);
      stop_recovery_src = 1'b1;
      cyc(5);
      chk("smr", c1, 8'h01);
      chk("in3tog", port3_read[2], 8'h00);
      stop_recovery_src = 1'b0;
      print_verdict();
   end
endmodule // port3_comparator_mux_tb
